// ---- inc/bgd_pkg.sv ----
package bgd_pkg;
	// ****************************************
	// Register map (word addresses)
	// ****************************************
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_DEAD   = 4'h1;
	localparam logic [3:0] ADDR_PERIOD = 4'h2;
	localparam logic [3:0] ADDR_DUTY   = 4'h3;
	localparam logic [3:0] ADDR_STAT   = 4'h4;
	localparam logic [3:0] ADDR_MASK   = 4'h5;
	localparam logic [3:0] ADDR_STATE  = 4'h6;
	// ****************************************
	// Control register fields
	// ****************************************
	localparam int CTL_ALL_OFF  = 0;
	localparam int CTL_HI_OFF   = 1;
	localparam int CTL_LO_OFF   = 2;
	localparam int CTL_LO_DLY   = 3;
	localparam int CTL_HI_DLY   = 4;
	localparam int CTL_HI_STR   = 5;
	localparam int CTL_PULLUP   = 6;
	localparam int CTL_PULLDN   = 7;
	localparam int CTL_UV_TRIP  = 8;
	localparam int CTL_OV_TRIP  = 9;
	localparam int CTL_TMR_ON   = 10;
	localparam int CTL_W        = 11;
	localparam logic [CTL_W-1:0] CTL_RESET = 11'h001;
	// ****************************************
	// Status register fields
	// ****************************************
	localparam int ST_UV     = 0;
	localparam int ST_OV     = 1;
	localparam int ST_PERIOD = 2;
	localparam int ST_W      = 3;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int DT_STEP_NS    = 4;
	// Dead-time step count: 4 ns rounds up to one 10 ns cycle
	localparam int DT_STEP_CYC   = (DT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FSW_MIN_KHZ   = 100;
	localparam int FSW_MAX_KHZ   = 1600;
	localparam int PER_MAX_CYC   = 1000000 / (CLK_PERIOD_NS * FSW_MIN_KHZ);
	localparam int PER_MIN_CYC   = 1000000 / (CLK_PERIOD_NS * FSW_MAX_KHZ);
	localparam logic [15:0] PERIOD_RESET = 16'(PER_MIN_CYC);
	localparam logic [15:0] DUTY_RESET   = 16'h0000;
endpackage

// ---- verilog/bgd_gate_ctrl.sv ----
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module bgd_gate_ctrl
	import bgd_pkg::*;
#(
	parameter int DT_W = 8
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Avalon-MM slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Fault comparator pins
	input  wire logic        undervolt_in,
	input  wire logic        overvolt_in,
	// Gate drive, analog controls and interrupt
	output logic             high_gate_out,
	output logic             low_gate_out,
	output logic             phase_drive_en,
	output logic             high_drive_strength_sel,
	output logic             sense_pos_pullup_en,
	output logic             sense_neg_pulldown_en,
	output logic             irq
);
	// ****************************************
	// Registers
	// ****************************************
	logic [CTL_W-1:0]  ctrl_q, ctrl_d;
	logic [2*DT_W-1:0] dead_q, dead_d;
	logic [15:0]       per_q, per_d, duty_q, duty_d;
	logic [ST_W-1:0]   stat_q, stat_d, mask_q, mask_d;
	logic [31:0]       rdata_q, rdata_d;
	logic              ack_q, ack_d;
	// Registered wait flag so the bus output comes straight from a flop
	logic              wreq_q;
	logic [15:0]       cnt_q, cnt_d;
	logic              pwm_q, pwm_d;
	logic [DT_W+1:0]   hdly_q, hdly_d, ldly_q, ldly_d;
	logic              hg_q, hg_d, lg_q, lg_d, irq_q, irq_d;
	logic              ph_q, ph_d, hs_q, pu_q, pd_q;
	logic [2:0]        uv_s_q, ov_s_q;
	logic              wr_hit, per_evt, uv_evt, ov_evt, trip, hi_want, lo_want;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Three stages; a level counts once stages two and three agree
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			uv_s_q <= 3'h0;
			ov_s_q <= 3'h0;
		end else begin
			uv_s_q <= {uv_s_q[1:0], undervolt_in};
			ov_s_q <= {ov_s_q[1:0], overvolt_in};
		end
	end
	assign uv_evt = uv_s_q[1] & uv_s_q[2];
	assign ov_evt = ov_s_q[1] & ov_s_q[2];

	// ****************************************
	// Avalon slave and register file
	// ****************************************
	// One wait state on every access keeps read data registered
	assign wr_hit = write & ~ack_q;
	always_comb begin
		ctrl_d  = ctrl_q;
		dead_d  = dead_q;
		per_d   = per_q;
		duty_d  = duty_q;
		mask_d  = mask_q;
		stat_d  = stat_q;
		rdata_d = rdata_q;
		ack_d   = (read | write) & ~ack_q;
		if (wr_hit) begin
			unique case (address)
				ADDR_CTRL:   ctrl_d = writedata[CTL_W-1:0];
				ADDR_DEAD:   dead_d = writedata[2*DT_W-1:0];
				ADDR_PERIOD: per_d  = writedata[15:0];
				ADDR_DUTY:   duty_d = writedata[15:0];
				ADDR_MASK:   mask_d = writedata[ST_W-1:0];
				ADDR_STAT:   stat_d = stat_q & ~writedata[ST_W-1:0];
				default:     ctrl_d = ctrl_q;
			endcase
		end
		// Set wins over a write-one clear in the same cycle
		if (uv_evt)
			stat_d[ST_UV] = 1'b1;
		if (ov_evt)
			stat_d[ST_OV] = 1'b1;
		if (per_evt)
			stat_d[ST_PERIOD] = 1'b1;
		if (read & ~ack_q) begin
			unique case (address)
				ADDR_CTRL:   rdata_d = 32'(ctrl_q);
				ADDR_DEAD:   rdata_d = 32'(dead_q);
				ADDR_PERIOD: rdata_d = 32'(per_q);
				ADDR_DUTY:   rdata_d = 32'(duty_q);
				ADDR_STAT:   rdata_d = 32'(stat_q);
				ADDR_MASK:   rdata_d = 32'(mask_q);
				ADDR_STATE:  rdata_d = {28'h0000000, ph_q, lg_q, hg_q, pwm_q};
				default:     rdata_d = 32'h00000000;
			endcase
		end
		irq_d = |(stat_d & mask_d);
	end
	assign waitrequest = wreq_q;
	assign readdata    = rdata_q;

	// ****************************************
	// Period timer and gate logic
	// ****************************************
	// Undervoltage and overvoltage trips hold gates while flag set
	assign trip = (ctrl_q[CTL_UV_TRIP] & stat_q[ST_UV]) | (ctrl_q[CTL_OV_TRIP] & stat_q[ST_OV]);
	assign per_evt = ctrl_q[CTL_TMR_ON] && (cnt_q >= per_q - 16'h0001);
	assign hi_want = pwm_q & ~ctrl_q[CTL_ALL_OFF] & ~ctrl_q[CTL_HI_OFF] & ~trip;
	assign lo_want = ~pwm_q & ctrl_q[CTL_TMR_ON] & ~ctrl_q[CTL_ALL_OFF] & ~ctrl_q[CTL_LO_OFF] & ~trip;
	always_comb begin
		cnt_d = per_evt ? 16'h0000 : (ctrl_q[CTL_TMR_ON] ? cnt_q + 16'h0001 : 16'h0000);
		pwm_d = ctrl_q[CTL_TMR_ON] && (cnt_d < duty_q);
		// Delay counters load step count times setting
		hdly_d = hdly_q;
		ldly_d = ldly_q;
		hg_d   = hg_q;
		lg_d   = lg_q;
		// High rises only after low is low for dead time
		if (!hi_want) begin
			hg_d   = 1'b0;
			hdly_d = (DT_W+2)'(dead_q[DT_W-1:0] * DT_STEP_CYC);
		end else if (!lg_q) begin
			if (hdly_q == '0 || !ctrl_q[CTL_HI_DLY])
				hg_d = 1'b1;
			else
				hdly_d = hdly_q - 1'b1;
		end
		if (!lo_want) begin
			lg_d   = 1'b0;
			ldly_d = (DT_W+2)'(dead_q[2*DT_W-1:DT_W] * DT_STEP_CYC);
		end else if (!hg_q) begin
			if (ldly_q == '0 || !ctrl_q[CTL_LO_DLY])
				lg_d = 1'b1;
			else
				ldly_d = ldly_q - 1'b1;
		end
		if (hg_d && lg_d)
			lg_d = 1'b0;
		// Global off: both low, switch node floats
		// Per-side off handled in the want terms
		// Trip forces gates low via want terms
		ph_d = ~ctrl_q[CTL_ALL_OFF];
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_q  <= CTL_RESET;
			dead_q  <= '0;
			per_q   <= PERIOD_RESET;
			duty_q  <= DUTY_RESET;
			stat_q  <= '0;
			mask_q  <= '0;
			rdata_q <= 32'h00000000;
			ack_q   <= 1'b0;
			wreq_q  <= 1'b1;
			irq_q   <= 1'b0;
			cnt_q   <= 16'h0000;
			pwm_q   <= 1'b0;
			hdly_q  <= '0;
			ldly_q  <= '0;
			hg_q    <= 1'b0;
			lg_q    <= 1'b0;
			ph_q    <= 1'b0;
			hs_q    <= 1'b0;
			pu_q    <= 1'b0;
			pd_q    <= 1'b0;
		end else begin
			ctrl_q  <= ctrl_d;
			dead_q  <= dead_d;
			per_q   <= per_d;
			duty_q  <= duty_d;
			stat_q  <= stat_d;
			mask_q  <= mask_d;
			rdata_q <= rdata_d;
			ack_q   <= ack_d;
			wreq_q  <= ~ack_d;
			irq_q   <= irq_d;
			cnt_q   <= cnt_d;
			pwm_q   <= pwm_d;
			hdly_q  <= hdly_d;
			ldly_q  <= ldly_d;
			hg_q    <= hg_d;
			lg_q    <= lg_d;
			ph_q    <= ph_d;
			hs_q    <= ctrl_q[CTL_HI_STR];
			pu_q    <= ctrl_q[CTL_PULLUP];
			pd_q    <= ctrl_q[CTL_PULLDN];
		end
	end
	assign high_gate_out           = hg_q;
	assign low_gate_out            = lg_q;
	assign phase_drive_en          = ph_q;
	assign high_drive_strength_sel = hs_q;
	assign sense_pos_pullup_en     = pu_q;
	assign sense_neg_pulldown_en   = pd_q;
	assign irq                     = irq_q;

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_low_fell;
		$fell(lg_q);
	endsequence
	AST_NO_OVERLAP: assert property (@(posedge clk_sys) disable iff (rst)
		!(hg_q && lg_q)) else $error("both gates high");
	AST_ALL_OFF: assert property (@(posedge clk_sys) disable iff (rst)
		ctrl_q[CTL_ALL_OFF] |=> !hg_q && !lg_q && !ph_q) else $error("global off ignored");
	AST_HI_OFF: assert property (@(posedge clk_sys) disable iff (rst)
		ctrl_q[CTL_HI_OFF] |=> !hg_q) else $error("high side not held off");
	AST_LO_OFF: assert property (@(posedge clk_sys) disable iff (rst)
		ctrl_q[CTL_LO_OFF] |=> !lg_q) else $error("low side not held off");
	AST_DEAD_HI: assert property (@(posedge clk_sys) disable iff (rst)
		s_low_fell |-> !hg_q) else $error("high rose with low falling");
	AST_DEAD_ONE: assert property (@(posedge clk_sys) disable iff (rst)
		ctrl_q[CTL_HI_DLY] && dead_q[DT_W-1:0] != '0 && $stable(dead_q) ##0 s_low_fell
		|=> !hg_q) else $error("high-side dead time too short");
	AST_UV_TRIP: assert property (@(posedge clk_sys) disable iff (rst)
		ctrl_q[CTL_UV_TRIP] && stat_q[ST_UV] |=> !hg_q && !lg_q) else $error("uv trip ignored");
	AST_OV_TRIP: assert property (@(posedge clk_sys) disable iff (rst)
		ctrl_q[CTL_OV_TRIP] && stat_q[ST_OV] |=> !hg_q && !lg_q) else $error("ov trip ignored");
	AST_STRENGTH: assert property (@(posedge clk_sys) disable iff (rst)
		##1 high_drive_strength_sel == $past(ctrl_q[CTL_HI_STR])) else $error("strength lag");
	AST_PULLUP: assert property (@(posedge clk_sys) disable iff (rst)
		##1 sense_pos_pullup_en == $past(ctrl_q[CTL_PULLUP])) else $error("pull-up lag");
	AST_PULLDN: assert property (@(posedge clk_sys) disable iff (rst)
		##1 sense_neg_pulldown_en == $past(ctrl_q[CTL_PULLDN])) else $error("pull-down lag");
	AST_PERIOD: assert property (@(posedge clk_sys) disable iff (rst)
		per_evt |=> cnt_q == 16'h0000) else $error("period counter not restarted");
endmodule

// ---- sim/bgd_fet_model.sv ----
`timescale 1ns/1ps
// ****************
// Gate pair watcher
// ****************
module bgd_fet_model (
	// Clock
	input  wire logic        clk_sys,
	// Gate pins
	input  wire logic        high_gate_out,
	input  wire logic        low_gate_out,
	// Observations
	output logic             overlap_q,
	output logic [7:0]       gap_q,
	output logic [15:0]      hi_cnt_q,
	output logic [15:0]      lo_cnt_q
);
	logic       hi_p;
	logic       lo_p;
	logic [7:0] off_n;
	initial begin
		overlap_q = 1'b0;
		gap_q = 8'h00;
		hi_cnt_q = 16'h0000;
		lo_cnt_q = 16'h0000;
		hi_p = 1'b0;
		lo_p = 1'b0;
		off_n = 8'h00;
	end
	always @(posedge clk_sys) begin
		hi_p <= high_gate_out;
		lo_p <= low_gate_out;
		off_n <= low_gate_out ? 8'h00 : off_n + 8'h01;
		if (high_gate_out && low_gate_out) begin
			overlap_q <= 1'b1;
		end
		if (high_gate_out && !hi_p) begin
			gap_q <= off_n;
			hi_cnt_q <= hi_cnt_q + 16'h0001;
		end
		if (low_gate_out && !lo_p) begin
			lo_cnt_q <= lo_cnt_q + 16'h0001;
		end
	end
endmodule

// ---- sim/buck_gate_drive_control_tb_top.sv ----
`timescale 1ns/1ps
module buck_gate_drive_control_tb_top;
	import bgd_pkg::*;
	// ****************
	// Stimulus and wiring
	// ****************
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  address = 4'h0;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [1:0]  flt = 2'b00;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        high_gate_out;
	logic        low_gate_out;
	logic        phase_drive_en;
	logic        hds;
	logic        pu;
	logic        pd;
	logic        irq;
	logic        overlap;
	logic [7:0]  gap;
	logic [15:0] hi_cnt;
	logic [15:0] lo_cnt;
	logic [31:0] rv;
	int          fails = 0;
	int          samples_checked = 0;
	always #5 clk_sys = ~clk_sys;
	bgd_gate_ctrl i_bgd_gate_ctrl (.clk_sys(clk_sys), .rst(rst), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .undervolt_in(flt[0]), .overvolt_in(flt[1]),
		.high_gate_out(high_gate_out), .low_gate_out(low_gate_out),
		.phase_drive_en(phase_drive_en), .high_drive_strength_sel(hds),
		.sense_pos_pullup_en(pu), .sense_neg_pulldown_en(pd), .irq(irq));
	bgd_fet_model i_bgd_fet_model (.clk_sys(clk_sys), .high_gate_out(high_gate_out),
		.low_gate_out(low_gate_out), .overlap_q(overlap), .gap_q(gap),
		.hi_cnt_q(hi_cnt), .lo_cnt_q(lo_cnt));
	// ****************
	// Tasks
	// ****************
	task print_verdict;
		if (fails == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	// Master holds the request until waitrequest is seen low
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do begin
			@(posedge clk_sys);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		rv = readdata;
		write <= 1'b0;
		read <= 1'b0;
		if (n >= 50) begin
			fails++;
			$display("BAD %0t bus timeout", $time);
		end
		@(posedge clk_sys);
	endtask
	task rd_chk(input logic [3:0] a, input logic [31:0] exp, input string m);
		bus(1'b0, a, 32'h0);
		chk(rv, exp, m);
	endtask
	// Edge counts over five 20-cycle periods after settling
	task cnt_chk(input logic [15:0] eh, input logic [15:0] el, input string m);
		logic [15:0] h0;
		logic [15:0] l0;
		repeat (40) @(posedge clk_sys);
		h0 = hi_cnt;
		l0 = lo_cnt;
		repeat (100) @(posedge clk_sys);
		chk({hi_cnt - h0, lo_cnt - l0}, {eh, el}, m);
	endtask
	// ****************
	// Sequence
	// ****************
	initial begin
		#900000;
		fails++;
		print_verdict;
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk({31'h0, phase_drive_en}, 32'h0, "phase on at reset");
		rd_chk(ADDR_CTRL, 32'(CTL_RESET), "ctrl reset");
		rd_chk(ADDR_PERIOD, 32'(PER_MIN_CYC), "period reset");
		rd_chk(4'hf, 32'h0, "unmapped read");
		bus(1'b1, ADDR_CTRL, 32'h0e0);
		repeat (2) @(posedge clk_sys);
		chk({29'h0, hds, pu, pd}, 32'h7, "analog bits set");
		bus(1'b1, ADDR_CTRL, 32'h0);
		repeat (2) @(posedge clk_sys);
		chk({29'h0, hds, pu, pd}, 32'h0, "analog bits clear");
		bus(1'b1, ADDR_PERIOD, 32'd20);
		bus(1'b1, ADDR_DUTY, 32'd8);
		bus(1'b1, ADDR_DEAD, 32'h0203);
		bus(1'b1, ADDR_CTRL, 32'h418);
		cnt_chk(16'd5, 16'd5, "switching");
		chk({31'h0, gap >= 8'd3}, 32'h1, "dead time short");
		bus(1'b1, ADDR_CTRL, 32'h400);
		cnt_chk(16'd5, 16'd5, "bypass switching");
		chk({31'h0, gap < 8'd3}, 32'h1, "bypass still delayed");
		bus(1'b1, ADDR_CTRL, 32'h41a);
		cnt_chk(16'd0, 16'd5, "high off");
		bus(1'b1, ADDR_CTRL, 32'h41c);
		cnt_chk(16'd5, 16'd0, "low off");
		bus(1'b1, ADDR_CTRL, 32'h419);
		cnt_chk(16'd0, 16'd0, "all off");
		chk({31'h0, phase_drive_en}, 32'h0, "phase on while off");
		bus(1'b1, ADDR_CTRL, 32'h418);
		cnt_chk(16'd5, 16'd5, "restore");
		bus(1'b1, ADDR_MASK, 32'h4);
		repeat (3) @(posedge clk_sys);
		chk({31'h0, irq}, 32'h1, "wrap irq");
		bus(1'b1, ADDR_MASK, 32'h0);
		repeat (3) @(posedge clk_sys);
		chk({31'h0, irq}, 32'h0, "masked irq");
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, ADDR_CTRL, 32'h418 | (32'h100 << i));
			bus(1'b1, ADDR_MASK, 32'h1 << i);
			flt[i] <= 1'b1;
			repeat (10) @(posedge clk_sys);
			flt[i] <= 1'b0;
			repeat (5) @(posedge clk_sys);
			chk({31'h0, irq}, 32'h1, "fault irq");
			cnt_chk(16'd0, 16'd0, "trip hold");
			bus(1'b0, ADDR_STAT, 32'h0);
			chk(rv & 32'h3, 32'h1 << i, "fault flag");
			bus(1'b1, ADDR_STAT, 32'h1 << i);
			repeat (3) @(posedge clk_sys);
			chk({31'h0, irq}, 32'h0, "irq clear");
			cnt_chk(16'd5, 16'd5, "trip release");
		end
		chk({31'h0, overlap}, 32'h0, "shoot-through");
		print_verdict;
	end
endmodule
